// ### rtl/uhr_top.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Flip-flop FIFO; depth must be a power of two
// ****************************************************************
module uhr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  // Clock and control
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          flush,
  // Fill side
  input  wire logic          push,
  input  wire logic [W-1:0]  din,
  input  wire logic [CW-1:0] cap,
  // Drain side
  input  wire logic          pop,
  output logic      [W-1:0]  dout,
  output logic      [CW-1:0] cnt,
  output logic               full,
  output logic               empty
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;
  wire           do_push;
  wire           do_pop;

  // Cap shrinks the FIFO to one entry in character mode
  assign full    = cnt_ff >= cap;
  assign empty   = cnt_ff == '0;
  assign do_push = push & ~full & ~flush;
  assign do_pop  = pop & ~empty & ~flush;
  assign dout    = mem_ff[rp_ff];
  assign cnt     = cnt_ff;

  // Data store carries no reset; only the pointers matter
  always_ff @(posedge clk) begin
    if (ce && do_push) begin
      mem_ff[wp_ff] <= din;
    end
  end

  // Pointers and fill count; flush clears both pointers and the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_ff  <= '0;
        rp_ff  <= '0;
        cnt_ff <= '0;
      end else begin
        wp_ff  <= wp_ff + PW'(do_push);
        rp_ff  <= rp_ff + PW'(do_pop);
        cnt_ff <= cnt_ff + CW'(do_push) - CW'(do_pop);
      end
    end
  end
endmodule : uhr_fifo

// ****************************************************************
// Serial port with APB register access
// ****************************************************************
module uhr_top #(
  parameter int DEPTH = 16,
  parameter int AW    = 12
) (
  // Clock, reset and enable
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Serial line
  input  wire logic          rxd,
  output logic               txd,
  // Modem lines
  input  wire logic          cts_n,
  input  wire logic          dsr_n,
  input  wire logic          ri_n,
  input  wire logic          dcd_n,
  output logic               rts_n,
  output logic               dtr_n,
  // Interrupt
  output logic               irq
);
  localparam int CW = $clog2(DEPTH) + 1;

  uhr_pkg::uhr_req_s  req;
  uhr_pkg::uhr_state_e tx_st_ff, rx_st_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff, pslverr_ff, irq_ff, txd_ff, rts_n_ff, dtr_n_ff;
  logic [7:0]  lcr_ff, scr_ff;
  logic [3:0]  ier_ff;
  logic [4:0]  mcr_ff;
  logic [15:0] div_ff, bcnt_ff;
  logic        fen_ff;
  logic [1:0]  trig_ff;
  logic        thr_rep_ff, thre_ff, txe_d_ff, tx_par_ff, rx_pb_ff, to_ff;
  logic [5:0]  tx_tk_ff, rx_tk_ff;
  logic [2:0]  tx_bit_ff, rx_bit_ff;
  logic [7:0]  tx_sh_ff, rx_sh_ff;
  logic [3:0]  err_ff, msd_ff, mprev_ff;
  logic [9:0]  to_cnt_ff;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire         mapped, capt, take, wr_en, rd_en, divisor_access_bit;
  wire         wr_thr, wr_ier, wr_fcr, rd_rb, rd_iir, rd_lsr, rd_msr;
  wire [7:0]   rd_mux, iir_val, lsr_val;
  wire [7:0]   rd_tab [8];

  // One wait state: pready rises in the second access cycle
  assign req    = {paddr[4:2], pwrite, pwdata[7:0]};
  assign mapped = (paddr[AW-1:5] == '0) && (paddr[1:0] == 2'b00);
  assign capt   = psel & penable & ~pready_ff;
  assign take   = psel & penable & pready_ff;
  assign wr_en  = take & req.wr & mapped;
  assign rd_en  = take & ~req.wr & mapped;
  assign divisor_access_bit   = lcr_ff[uhr_pkg::LCR_DIVISOR_ACCESS_BIT];
  assign wr_thr = wr_en & (req.idx == uhr_pkg::IDX_DATA) & ~divisor_access_bit;
  assign wr_ier = wr_en & (req.idx == uhr_pkg::IDX_IER) & ~divisor_access_bit;
  assign wr_fcr = wr_en & (req.idx == uhr_pkg::IDX_IIR);
  assign rd_rb  = rd_en & (req.idx == uhr_pkg::IDX_DATA) & ~divisor_access_bit;
  assign rd_iir = rd_en & (req.idx == uhr_pkg::IDX_IIR);
  assign rd_lsr = rd_en & (req.idx == uhr_pkg::IDX_LSR);
  assign rd_msr = rd_en & (req.idx == uhr_pkg::IDX_MSR);

  // Read selection by index
  wire [7:0]   rx_head;
  assign rd_tab[0] = divisor_access_bit ? div_ff[7:0] : rx_head;
  assign rd_tab[1] = divisor_access_bit ? div_ff[15:8] : {4'h0, ier_ff};
  assign rd_tab[2] = iir_val;
  assign rd_tab[3] = lcr_ff;
  assign rd_tab[4] = {3'h0, mcr_ff};
  assign rd_tab[5] = lsr_val;
  assign rd_tab[6] = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n, msd_ff};
  assign rd_tab[7] = scr_ff;
  assign rd_mux    = mapped ? rd_tab[req.idx] : 8'h00;

  // ****************************************************************
  // Baud generator and line format
  // ****************************************************************
  wire [15:0]  div_m1;
  wire         tick;
  wire [3:0]   wlen, cbits;
  wire [7:0]   wmask;
  wire [5:0]   stop_tk;
  wire         pen;

  // Divisor 0 wraps to the slowest rate rather than stopping
  assign div_m1  = div_ff - 16'h0001;
  assign tick    = bcnt_ff >= div_m1;
  assign wlen    = 4'h5 + {2'b00, lcr_ff[1:0]};
  assign wmask   = 8'hff >> (2'h3 - lcr_ff[1:0]);
  assign pen     = lcr_ff[uhr_pkg::LCR_PEN];
  assign stop_tk = !lcr_ff[uhr_pkg::LCR_STOP] ? uhr_pkg::OVS :
                   (lcr_ff[1:0] == 2'b00) ? uhr_pkg::STOP15 : uhr_pkg::STOP2;
  assign cbits   = wlen + 4'h2 + {3'h0, pen};

  // Parity bit for masked data: even, odd or stuck
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lcr);
    par_bit = lcr[uhr_pkg::LCR_STICK] ? ~lcr[uhr_pkg::LCR_EVEN] :
              (lcr[uhr_pkg::LCR_EVEN] ? ^d : ~^d);
  endfunction : par_bit

  // Sixteen ticks per bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_ff <= 16'h0000;
    end else if (ce) begin
      bcnt_ff <= tick ? 16'h0000 : bcnt_ff + 16'h0001;
    end
  end

  // ****************************************************************
  // FIFOs
  // ****************************************************************
  wire [CW-1:0] cap, tx_cnt, rx_cnt;
  wire [7:0]    tx_head, rx_data;
  wire          tx_empty, rx_full, tx_pop, rx_end, rx_push;
  wire          fen_w, tx_flush, rx_flush;

  // Other bits act only with enable set; leaving or entering FIFO mode flushes
  assign fen_w    = pwdata[uhr_pkg::FCR_EN];
  assign rx_flush = wr_fcr & (~fen_w | ~fen_ff | pwdata[uhr_pkg::FCR_RXCLR]);
  assign tx_flush = wr_fcr & (~fen_w | ~fen_ff | pwdata[uhr_pkg::FCR_TXCLR]);
  assign cap      = fen_ff ? CW'(DEPTH) : CW'(1);
  assign tx_pop   = (tx_st_ff == uhr_pkg::ST_IDLE) & ~tx_empty;
  assign rx_data  = rx_sh_ff >> (2'h3 - lcr_ff[1:0]);
  assign rx_end   = tick & (rx_st_ff == uhr_pkg::ST_STOP) & (rx_tk_ff == uhr_pkg::OVS - 6'h01);
  assign rx_push  = rx_end & ~rx_full;

  uhr_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .flush (tx_flush),
    .push  (wr_thr),
    .din   (req.wdata),
    .cap   (cap),
    .pop   (tx_pop),
    .dout  (tx_head),
    .cnt   (tx_cnt),
    .full  (),
    .empty (tx_empty)
  );

  uhr_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .flush (rx_flush),
    .push  (rx_push),
    .din   (rx_data),
    .cap   (cap),
    .pop   (rd_rb),
    .dout  (rx_head),
    .cnt   (rx_cnt),
    .full  (rx_full),
    .empty ()
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Software state; the scratch byte steers nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcr_ff  <= uhr_pkg::LCR_RST;
      ier_ff  <= uhr_pkg::IER_RST;
      mcr_ff  <= uhr_pkg::MCR_RST;
      div_ff  <= uhr_pkg::DIV_RST;
      scr_ff  <= uhr_pkg::SCR_RST;
      fen_ff  <= 1'b0;
      trig_ff <= 2'b00;
    end else if (ce && wr_en) begin
      unique case (req.idx)
        uhr_pkg::IDX_DATA: if (divisor_access_bit) div_ff[7:0] <= req.wdata;
        uhr_pkg::IDX_IER: begin
          if (divisor_access_bit) div_ff[15:8] <= req.wdata;
          else ier_ff <= req.wdata[3:0];
        end
        uhr_pkg::IDX_IIR: begin
          fen_ff <= fen_w;
          if (fen_w) trig_ff <= req.wdata[uhr_pkg::FCR_TRIG+:2];
        end
        uhr_pkg::IDX_LCR: lcr_ff <= req.wdata;
        uhr_pkg::IDX_MCR: mcr_ff <= req.wdata[4:0];
        uhr_pkg::IDX_LSR: ;
        uhr_pkg::IDX_MSR: ;
        uhr_pkg::IDX_SCR: scr_ff <= req.wdata;
      endcase
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  wire tx_lvl, tx_last;
  assign tx_lvl  = (tx_st_ff == uhr_pkg::ST_START) ? 1'b0 :
                   (tx_st_ff == uhr_pkg::ST_DATA) ? tx_sh_ff[0] :
                   (tx_st_ff == uhr_pkg::ST_PAR) ? tx_par_ff : 1'b1;
  assign tx_last = tick & (tx_tk_ff == ((tx_st_ff == uhr_pkg::ST_STOP) ? stop_tk : uhr_pkg::OVS) - 6'h01);

  // Frame sequencer; shifter only reloads after the stop bit ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff  <= uhr_pkg::ST_IDLE;
      tx_tk_ff  <= 6'h00;
      tx_bit_ff <= 3'h0;
      tx_sh_ff  <= 8'h00;
      tx_par_ff <= 1'b0;
    end else if (ce) begin
      tx_tk_ff <= tx_last ? 6'h00 : tx_tk_ff + 6'(tick);
      unique case (tx_st_ff)
        uhr_pkg::ST_IDLE: begin
          tx_tk_ff <= 6'h00;
          if (tx_pop) begin
            tx_sh_ff  <= tx_head & wmask;
            tx_par_ff <= par_bit(tx_head & wmask, lcr_ff);
            tx_st_ff  <= uhr_pkg::ST_START;
          end
        end
        uhr_pkg::ST_START: if (tx_last) begin
          tx_bit_ff <= 3'h0;
          tx_st_ff  <= uhr_pkg::ST_DATA;
        end
        uhr_pkg::ST_DATA: if (tx_last) begin
          tx_sh_ff  <= tx_sh_ff >> 1;
          tx_bit_ff <= tx_bit_ff + 3'h1;
          if ({1'b0, tx_bit_ff} == wlen - 4'h1) tx_st_ff <= pen ? uhr_pkg::ST_PAR : uhr_pkg::ST_STOP;
        end
        uhr_pkg::ST_PAR: if (tx_last) tx_st_ff <= uhr_pkg::ST_STOP;
        uhr_pkg::ST_STOP: if (tx_last) tx_st_ff <= uhr_pkg::ST_IDLE;
        default: tx_st_ff <= uhr_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  wire rx_mid;
  assign rx_mid = tick & (rx_tk_ff == (((rx_st_ff == uhr_pkg::ST_START) ? uhr_pkg::HALF : uhr_pkg::OVS) - 6'h01));

  // Start bit is checked at mid bit so glitches do not start a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff  <= uhr_pkg::ST_IDLE;
      rx_tk_ff  <= 6'h00;
      rx_bit_ff <= 3'h0;
      rx_sh_ff  <= 8'h00;
      rx_pb_ff  <= 1'b0;
    end else if (ce) begin
      rx_tk_ff <= rx_mid ? 6'h00 : rx_tk_ff + 6'(tick);
      unique case (rx_st_ff)
        uhr_pkg::ST_IDLE: begin
          rx_tk_ff <= 6'h00;
          if (!rxd) rx_st_ff <= uhr_pkg::ST_START;
        end
        uhr_pkg::ST_START: if (rx_mid) begin
          rx_bit_ff <= 3'h0;
          rx_st_ff  <= rxd ? uhr_pkg::ST_IDLE : uhr_pkg::ST_DATA;
        end
        uhr_pkg::ST_DATA: if (rx_mid) begin
          rx_sh_ff  <= {rxd, rx_sh_ff[7:1]};
          rx_bit_ff <= rx_bit_ff + 3'h1;
          if ({1'b0, rx_bit_ff} == wlen - 4'h1) rx_st_ff <= pen ? uhr_pkg::ST_PAR : uhr_pkg::ST_STOP;
        end
        uhr_pkg::ST_PAR: if (rx_mid) begin
          rx_pb_ff <= rxd;
          rx_st_ff <= uhr_pkg::ST_STOP;
        end
        uhr_pkg::ST_STOP: if (rx_mid) rx_st_ff <= uhr_pkg::ST_IDLE;
        default: rx_st_ff <= uhr_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Line and modem status
  // ****************************************************************
  wire [3:0] err_set, mnow, msd_set;
  // Sticky {break, framing, parity, overrun}; only the first stop bit is checked
  assign err_set = rx_end ? {~rxd & (rx_data == 8'h00) & ~(pen & rx_pb_ff), ~rxd,
                             pen & (rx_pb_ff != par_bit(rx_data, lcr_ff)), rx_full} : 4'h0;
  assign lsr_val = {fen_ff & |err_ff[3:1], tx_empty & (tx_st_ff == uhr_pkg::ST_IDLE),
                    tx_empty, err_ff, rx_cnt != '0};
  assign mnow    = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
  // Ring reports its trailing edge only, as modems expect
  assign msd_set = {mnow[3] ^ mprev_ff[3], ~mnow[2] & mprev_ff[2], mnow[1:0] ^ mprev_ff[1:0]};

  // Reads clear the status; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff   <= 4'h0;
      msd_ff   <= 4'h0;
      mprev_ff <= 4'h0;
    end else if (ce) begin
      err_ff   <= (rd_lsr ? 4'h0 : err_ff) | err_set;
      msd_ff   <= (rd_msr ? 4'h0 : msd_ff) | msd_set;
      mprev_ff <= mnow;
    end
  end

  // ****************************************************************
  // Character timeout and holding empty tracking
  // ****************************************************************
  wire [9:0] to_lim;
  wire       rx_act, thre_set, thre_clr;
  assign to_lim   = {cbits, 6'h00} - 10'h001;
  assign rx_act   = rx_push | rd_rb | rx_flush | (rx_cnt == '0);
  assign thre_set = (tx_empty & ~txe_d_ff) | (wr_ier & req.wdata[uhr_pkg::IER_THR] & tx_empty);
  assign thre_clr = wr_thr | (rd_iir & thr_rep_ff);

  // Four character times of oversampled ticks with no FIFO traffic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_ff <= 10'h000;
      to_ff     <= 1'b0;
      thre_ff   <= 1'b0;
      txe_d_ff  <= 1'b1;
    end else if (ce) begin
      if (rx_act) begin
        to_cnt_ff <= 10'h000;
        to_ff     <= 1'b0;
      end else if (tick && !to_ff) begin
        to_cnt_ff <= to_cnt_ff + 10'h001;
        to_ff     <= to_cnt_ff == to_lim;
      end
      thre_ff  <= (thre_ff & ~thre_clr) | thre_set;
      txe_d_ff <= tx_empty;
    end
  end

  // ****************************************************************
  // Interrupt identification
  // ****************************************************************
  wire       s_rls, s_rda, s_cto, s_thr, s_msi, pend;
  wire [2:0] iid;
  assign s_rls   = ier_ff[uhr_pkg::IER_RLS] & |err_ff;
  assign s_rda   = ier_ff[uhr_pkg::IER_RDA] & (fen_ff ? (rx_cnt >= CW'(uhr_pkg::TRIG_LVL[trig_ff])) :
                   (rx_cnt != '0));
  assign s_cto   = ier_ff[uhr_pkg::IER_RDA] & fen_ff & to_ff;
  assign s_thr   = ier_ff[uhr_pkg::IER_THR] & thre_ff;
  assign s_msi   = ier_ff[uhr_pkg::IER_MSI] & |msd_ff;
  assign pend    = s_rls | s_rda | s_cto | s_thr | s_msi;
  assign iid     = s_rls ? uhr_pkg::IID_RLS : s_rda ? uhr_pkg::IID_RDA : s_cto ? uhr_pkg::IID_CTO :
                   s_thr ? uhr_pkg::IID_THR : uhr_pkg::IID_MSI;
  assign iir_val = {fen_ff, fen_ff, 2'b00, pend ? iid : 3'h0, ~pend};

  // ****************************************************************
  // Output flops
  // ****************************************************************
  // Read data is frozen at the first access cycle, so identify cannot shift mid access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
      thr_rep_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= capt;
      if (capt) begin
        prdata_ff  <= {24'h000000, rd_mux};
        pslverr_ff <= ~mapped;
        thr_rep_ff <= pend & (iid == uhr_pkg::IID_THR);
      end
    end
  end

  // Line pins and gated interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_ff   <= 1'b1;
      rts_n_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
      irq_ff   <= 1'b0;
    end else if (ce) begin
      txd_ff   <= tx_lvl & ~lcr_ff[uhr_pkg::LCR_BRK];
      rts_n_ff <= ~mcr_ff[uhr_pkg::MCR_RTS];
      dtr_n_ff <= ~mcr_ff[uhr_pkg::MCR_DTR];
      irq_ff   <= pend & mcr_ff[uhr_pkg::MCR_GATE];
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign txd     = txd_ff;
  assign rts_n   = rts_n_ff;
  assign dtr_n   = dtr_n_ff;
  assign irq     = irq_ff;
endmodule : uhr_top

`default_nettype wire

// ### rtl/uhr_pkg.sv
// ****************************************************************
// Register map, field positions and line timing
// ****************************************************************
package uhr_pkg;
  // Register index; byte address is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_IER  = 3'h1;
  localparam logic [2:0] IDX_IIR  = 3'h2;
  localparam logic [2:0] IDX_LCR  = 3'h3;
  localparam logic [2:0] IDX_MCR  = 3'h4;
  localparam logic [2:0] IDX_LSR  = 3'h5;
  localparam logic [2:0] IDX_MSR  = 3'h6;
  localparam logic [2:0] IDX_SCR  = 3'h7;
  // Line format control fields
  localparam int LCR_STOP  = 2;
  localparam int LCR_PEN   = 3;
  localparam int LCR_EVEN  = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BRK   = 6;
  localparam int LCR_DIVISOR_ACCESS_BIT  = 7;
  // Modem line control fields
  localparam int MCR_DTR  = 0;
  localparam int MCR_RTS  = 1;
  localparam int MCR_GATE = 3;
  // Interrupt enable fields
  localparam int IER_RDA = 0;
  localparam int IER_THR = 1;
  localparam int IER_RLS = 2;
  localparam int IER_MSI = 3;
  // FIFO control fields
  localparam int FCR_EN    = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int FCR_TRIG  = 6;
  // Interrupt source codes for identification bits 3:1
  localparam logic [2:0] IID_RLS = 3'h3;
  localparam logic [2:0] IID_RDA = 3'h2;
  localparam logic [2:0] IID_CTO = 3'h6;
  localparam logic [2:0] IID_THR = 3'h1;
  localparam logic [2:0] IID_MSI = 3'h0;
  // Reset values
  localparam logic [7:0]  LCR_RST = 8'h03;
  localparam logic [3:0]  IER_RST = 4'h0;
  localparam logic [4:0]  MCR_RST = 5'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [7:0]  SCR_RST = 8'h00;
  // Oversampling ticks per bit, half bit, stop lengths, timeout chars
  localparam logic [5:0] OVS      = 6'h10;
  localparam logic [5:0] HALF     = 6'h08;
  localparam logic [5:0] STOP15   = 6'h18;
  localparam logic [5:0] STOP2    = 6'h20;
  localparam int         TO_CHARS = 4;
  // Receive trigger levels in bytes, indexed by the trigger field
  localparam logic [3:0][4:0] TRIG_LVL = {5'h0e, 5'h08, 5'h04, 5'h01};
  // Serial engine states, Gray coded along the frame
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b011,
    ST_PAR   = 3'b010,
    ST_STOP  = 3'b110
  } uhr_state_e;
  // Register request as decoded from the bus
  typedef struct packed {
    logic [2:0] idx;
    logic       wr;
    logic [7:0] wdata;
  } uhr_req_s;
endpackage : uhr_pkg

// ### tb/uhr_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Port checks on the APB answer and the line
// ****************************************************************
module uhr_sva #(parameter int AW = 12) (
  // Watched ports
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          txd,
  input wire logic          irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer timing and shape
  chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
    else $error("pready not after one wait state");
  chk_err_bad: assert property (pready && (paddr[1:0] != 2'h0 || paddr[AW-1:5] != '0) |-> pslverr)
    else $error("unmapped access without pslverr");
  chk_err_good: assert property (pready && paddr[1:0] == 2'h0 && paddr[AW-1:5] == '0 |-> !pslverr)
    else $error("pslverr on mapped access");
  chk_rd_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  chk_rd_hold: assert property ($changed(prdata) |-> pready)
    else $error("prdata moved outside answer");
  // Identify read shape: fifo bits paired, reserved zero, legal code
  chk_iir_code: assert property (pready && !pwrite && paddr == 'h8 |-> prdata[5:4] == 2'h0 &&
    prdata[7] == prdata[6] && prdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
    else $error("bad identify value");
  // Outputs quiet right after reset
  chk_txd_rst: assert property ($rose(presetn) |-> txd)
    else $error("txd low after reset");
  chk_irq_rst: assert property ($rose(presetn) |-> !irq)
    else $error("irq high after reset");
  cover property (pready && pslverr);
  cover property (pready && !pwrite && paddr == 'h8 && !prdata[0]);
  cover property ($fell(txd));
endmodule : uhr_sva

bind uhr_top uhr_sva #(.AW(AW)) sva_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .txd, .irq);
`default_nettype wire

// ### tb/uhr_line_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Remote serial device, 8N1, divisor 1 gives 16 clocks a bit
// ****************************************************************
module uhr_line_peer #(parameter int BT = 16) (
  // Line
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got;
  int         n = 0;
  initial rxd = 1'b1;
  // Mid-bit sampling; stop bit only counted, framing is not judged here
  always begin : rx_p
    @(negedge txd);
    repeat (BT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge pclk);
      got[i] = txd;
    end
    repeat (BT) @(posedge pclk);
    n++;
  end
  // Start, eight bits first bit lowest, one stop
  task send(input logic [7:0] d);
    for (int i = -1; i < 9; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : d[i];
      repeat (BT) @(posedge pclk);
    end
  endtask : send
endmodule : uhr_line_peer
`default_nettype wire

// ### tb/uhr_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
// ****************************************************************
// Bench top: APB master, line peer, scenarios
// ****************************************************************
module uhr_top_tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, rxd, txd, irq, rts_n, dtr_n;
  logic        cts_n = 1'b1, dsr_n = 1'b1, ri_n = 1'b1, dcd_n = 1'b1;
  int          miscompares = 0, tests_run = 0, cyc = 0;
  // Clock enable tied high; modem lines are driven and watched by the bench
  uhr_top dut_u (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rxd, .txd, .cts_n, .dsr_n, .ri_n, .dcd_n, .rts_n, .dtr_n, .irq);
  uhr_line_peer peer_u (.pclk, .txd, .rxd);
  initial forever #5 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      summarize();
    end
  end
  // One APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, {7'h0, i, 2'h0}, d);
  endtask : wr
  task automatic ck(input logic [2:0] i, input logic [7:0] e);
    apb(1'b0, {7'h0, i, 2'h0}, 8'h00);
    `CHK($sformatf("reg%0d", i), {24'h0, e}, rd)
  endtask : ck
  task automatic wait_rx(input int k);
    for (int t = 0; t < 2000 && peer_u.n < k; t++) @(posedge pclk);
    if (peer_u.n < k) miscompares++;
  endtask : wait_rx
  // Registered outputs are read one edge after the write launches them
  task automatic chk_irq(input logic e);
    @(posedge pclk);
    `CHK("irq", e, irq)
  endtask : chk_irq
  // Reset values
  task t_reset;
    ck(3, 8'h03);
    ck(1, 8'h00);
    ck(4, 8'h00);
    ck(2, 8'h01);
    `CHK("irq", 1'b0, irq)
    $display("test reset done");
  endtask : t_reset
  // Divisor access remap, scratch, enable read-back
  task t_map;
    wr(7, 8'ha5);
    wr(1, 8'hff);
    ck(1, 8'h0f);
    wr(3, 8'h83);
    wr(1, 8'h00);
    wr(0, 8'h01);
    ck(1, 8'h00);
    ck(7, 8'ha5);
    wr(3, 8'h03);
    ck(1, 8'h0f);
    wr(1, 8'h00);
    $display("test map done");
  endtask : t_map
  // Holding empty interrupt, gate, back to back transmit
  task t_tx;
    wr(4, 8'h08);
    wr(1, 8'h02);
    chk_irq(1'b1);
    wr(4, 8'h00);
    chk_irq(1'b0);
    wr(4, 8'h08);
    ck(2, 8'h02);
    ck(2, 8'h01);
    wr(0, 8'h35);
    wr(0, 8'hca);
    wait_rx(1);
    `CHK("tx1", 8'h35, peer_u.got)
    wait_rx(2);
    `CHK("tx2", 8'hca, peer_u.got)
    wr(1, 8'h00);
    $display("test tx done");
  endtask : t_tx
  // Receive FIFO trigger, disable, flush, timeout
  task t_rx;
    wr(1, 8'h01);
    wr(2, 8'h41);
    peer_u.send(8'h11);
    peer_u.send(8'h22);
    peer_u.send(8'h33);
    ck(2, 8'hc1);
    peer_u.send(8'h44);
    ck(2, 8'hc4);
    ck(0, 8'h11);
    wr(1, 8'h00);
    ck(2, 8'hc1);
    wr(1, 8'h01);
    wr(2, 8'h43);
    ck(5, 8'h60);
    peer_u.send(8'h55);
    repeat (800) @(posedge pclk);
    ck(2, 8'hcc);
    ck(0, 8'h55);
    wr(2, 8'h00);
    ck(2, 8'h01);
    wr(1, 8'h04);
    peer_u.send(8'h66);
    peer_u.send(8'h77);
    ck(2, 8'h06);
    ck(5, 8'h63);
    ck(0, 8'h66);
    wr(1, 8'h00);
    $display("test rx done");
  endtask : t_rx
  // Modem delta interrupt and control pins
  task t_modem;
    wr(1, 8'h08);
    cts_n <= 1'b0;
    wr(4, 8'h0b);
    ck(2, 8'h00);
    chk_irq(1'b1);
    `CHK("pins", 2'b00, {rts_n, dtr_n})
    ck(6, 8'h11);
    ck(2, 8'h01);
    cts_n <= 1'b1;
    wr(4, 8'h00);
    chk_irq(1'b0);
    `CHK("pins", 2'b11, {rts_n, dtr_n})
    wr(1, 8'h00);
    $display("test modem done");
  endtask : t_modem
  // Unmapped accesses refused without effect
  task t_err;
    apb(1'b0, 12'h001, 8'h00);
    `CHK("err", 1'b1, er)
    apb(1'b1, 12'h03c, 8'h77);
    `CHK("err", 1'b1, er)
    ck(7, 8'ha5);
    $display("test err done");
  endtask : t_err
  task summarize;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_map();
    t_tx();
    t_rx();
    t_modem();
    t_err();
    summarize();
  end
endmodule : uhr_top_tb_top
`default_nettype wire
